// file: hdl/sadtc_pkg.sv
/*
  Shared constants and types of the converter control and DMA data block.
  Assumes a 32-bit register bus with byte addresses and a single clock.
*/
package sadtc_pkg;

  // Register byte offsets
  localparam logic [6:0] SADTC_DMAWORD_OFS = 7'h50;
  localparam logic [6:0] SADTC_ACTL_OFS    = 7'h5C;
  localparam logic [6:0] SADTC_CTL_OFS     = 7'h60;
  localparam logic [6:0] SADTC_STAT_OFS    = 7'h78;
  localparam logic [6:0] SADTC_MASK_OFS    = 7'h7C;

  // Values after reset
  localparam logic [31:0] SADTC_ACTL_RST = 32'h0000_0000;
  localparam logic [31:0] SADTC_CTL_RST  = 32'h0000_0000;
  localparam logic [31:0] SADTC_WORD_RST = 32'h0000_0000;
  localparam logic [2:0]  SADTC_IRQ_RST  = 3'h0;

  // Writable bits; all others read as zero
  localparam logic [31:0] SADTC_ACTL_WMASK = 32'h0004_0001;
  localparam logic [31:0] SADTC_CTL_WMASK  = 32'h0000_0BFF;

  // Field positions and the monitor word width
  localparam int SADTC_VREF_BIT = 18;
  localparam int SADTC_SE_BIT   = 0;
  localparam int SADTC_MON_W    = 18;

  // Interrupt status bits
  localparam int SADTC_IRQ_END  = 0;
  localparam int SADTC_IRQ_OVR  = 1;
  localparam int SADTC_IRQ_TRIG = 2;

  // Start pin stability, in clock cycles
  localparam logic [3:0] SADTC_LEVEL_CYC = 4'h8;
  localparam logic [3:0] SADTC_EDGE_CYC  = 4'h4;

  // Trigger source: external start pin
  localparam logic [1:0] SADTC_SRC_PIN = 2'h0;

  typedef enum logic [1:0] {
    SADTC_SINGLE, SADTC_RSVD, SADTC_SCAN1, SADTC_SCANC
  } sadtc_mode_t;

  typedef enum logic [1:0] {
    SADTC_LOW, SADTC_HIGH, SADTC_FALL, SADTC_RISE
  } sadtc_cond_t;

  // Control register layout
  typedef struct packed {
    logic [19:0] rsvdHi;
    logic        start;
    logic        rsvd10;
    logic        dmaEn;
    logic        hwEn;
    sadtc_cond_t trigCond;
    logic [1:0]  trigSel;
    sadtc_mode_t mode;
    logic        irqEn;
    logic        adcEn;
  } sadtc_ctl_t;

  // Result register content from the converter core
  typedef struct packed {
    logic        valid;
    logic        ov;
    logic [11:0] result;
  } sadtc_result_t;

endpackage

// file: hdl/sadtc_ctrl.sv
/*
  Control and DMA data path of a SAR converter: start bit in every mode,
  start pin trigger, DMA request and monitor word, reference select and
  an interrupt status/mask pair.
  Assumes an Avalon-MM master, a converter core and a DMA controller,
  all on clk; only the start pin comes from outside the clock domain.
*/
// Our own choice: the Avalon-MM slave port.
module sadtc_ctrl
  import sadtc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Avalon-MM register slave
  input  wire logic [6:0]    avsAddress,
  input  wire logic          avsRead,
  input  wire logic          avsWrite,
  input  wire logic [3:0]    avsByteEnable,
  input  wire logic [31:0]   avsWriteData,
  output logic      [31:0]   avsReadData,
  output logic               avsWaitRequest,
  // Converter core
  input  wire logic          convDone,
  input  wire sadtc_result_t convResult,
  input  wire logic          cycleDone,
  output logic               convRun,
  output logic               adcEnable,
  output sadtc_mode_t        operating_mode_field,
  output logic               refMicBias,
  output logic               singleEnded,
  // External start pin
  input  wire logic          extStartPin,
  // DMA controller
  input  wire logic          dmaWord32,
  input  wire logic          dmaAck,
  output logic               dmaReq,
  output logic      [31:0]   dmaData,
  // Interrupt
  output logic               irq
);

  // Merge byte-enabled write data into the writable bits
  function automatic logic [31:0] sadtcMerge(input logic [31:0] old,
    input logic [31:0] wd, input logic [3:0] be, input logic [31:0] wm);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    m = m & wm;
    return (old & ~m) | (wd & m);
  endfunction

  sadtc_ctl_t  ctl_reg;
  sadtc_ctl_t  ctl_next;
  logic [31:0] actl_reg;
  logic [31:0] word_reg;
  logic        dmaReq_reg;
  logic [2:0]  stat_reg;
  logic [2:0]  stat_next;
  logic [2:0]  mask_reg;
  logic        irq_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;
  logic [2:0]  pinSync_reg;
  logic        pinLevel_reg;
  logic [3:0]  stable_reg;
  logic        startNext;

  // Bus decode
  wire        reqValid  = avsRead | avsWrite;
  wire        accept    = reqValid & ~wait_reg;
  wire        wrAccept  = avsWrite & accept;
  wire        hitWord   = avsAddress == SADTC_DMAWORD_OFS;
  wire        hitActl   = avsAddress == SADTC_ACTL_OFS;
  wire        hitCtl    = avsAddress == SADTC_CTL_OFS;
  wire        hitStat   = avsAddress == SADTC_STAT_OFS;
  wire        hitMask   = avsAddress == SADTC_MASK_OFS;
  wire        wrCtl     = wrAccept & hitCtl;
  wire        wrActl    = wrAccept & hitActl;
  wire        wrStat    = wrAccept & hitStat;
  wire        wrMask    = wrAccept & hitMask;
  wire        swStart   = wrCtl & avsByteEnable[1];
  wire [31:0] ctlMerged = sadtcMerge(ctl_reg, avsWriteData, avsByteEnable,
                                     SADTC_CTL_WMASK);
  wire [31:0] maskMerged = sadtcMerge({29'h0, mask_reg}, avsWriteData,
                                      avsByteEnable, 32'h0000_0007);
  wire [2:0]  statClr   = (wrStat & avsByteEnable[0]) ? avsWriteData[2:0] : 3'h0;

  // side-effect-free monitor
  // Monitor word shows only the low 18 bits
  wire [SADTC_MON_W-1:0] monWord = word_reg[SADTC_MON_W-1:0];

  // Read data selection; unmapped addresses read zero
  wire [31:0] rdMux =
    hitWord ? {14'h0, monWord} :
    hitActl ? actl_reg :
    hitCtl  ? ctl_reg :
    hitStat ? {29'h0, stat_reg} :
    hitMask ? {29'h0, mask_reg} : 32'h0000_0000;

  // Bus handshake: one wait cycle, read data captured before release
  always_ff @(posedge clk) begin
    if (reset) begin
      wait_reg  <= 1'h1;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wait_reg <= ~(reqValid & wait_reg);
      if (avsRead & wait_reg) begin
        rdata_reg <= rdMux;
      end
    end
  end

  // Start pin synchroniser; the level moves once stages two and three agree
  wire pinAgree  = pinSync_reg[1] == pinSync_reg[2];
  wire pinChange = pinAgree & (pinSync_reg[2] != pinLevel_reg);
  always_ff @(posedge clk) begin
    if (reset) begin
      pinSync_reg  <= 3'h0;
      pinLevel_reg <= 1'h0;
      stable_reg   <= 4'h0;
    end else begin
      pinSync_reg <= {pinSync_reg[1:0], extStartPin};
      if (pinChange) begin
        pinLevel_reg <= pinSync_reg[2];
        stable_reg   <= 4'h1;
      end else if (stable_reg != SADTC_LEVEL_CYC) begin
        stable_reg <= stable_reg + 4'h1;
      end
    end
  end

  // Trigger condition; edges need the old level held long enough
  wire edgeOk  = pinChange & (stable_reg >= SADTC_EDGE_CYC);
  wire levelOk = stable_reg == SADTC_LEVEL_CYC;
  wire pinEvent =
    (ctl_reg.trigCond == SADTC_LOW)  ? levelOk & ~pinLevel_reg :
    (ctl_reg.trigCond == SADTC_HIGH) ? levelOk & pinLevel_reg :
    (ctl_reg.trigCond == SADTC_FALL) ? edgeOk & ~pinSync_reg[2] :
                                       edgeOk & pinSync_reg[2];

  wire hwFire = ctl_reg.hwEn & (ctl_reg.mode == SADTC_SCAN1) &
                (ctl_reg.trigSel == SADTC_SRC_PIN) & pinEvent;

  wire autoStop = cycleDone & ctl_reg.start &
                  ((ctl_reg.mode == SADTC_SINGLE) | (ctl_reg.mode == SADTC_SCAN1));

  // Start bit: end of pass clears in single and single-cycle scan modes, software writes, hardware set wins
  always_comb begin
    startNext = ctl_reg.start;
    if (autoStop) begin
      startNext = 1'h0;
    end
    if (swStart) begin
      startNext = ctlMerged[11];
    end
    if (hwFire) begin
      startNext = 1'h1;
    end
  end

  // control next value, reserved bits masked
  always_comb begin
    ctl_next       = wrCtl ? sadtc_ctl_t'(ctlMerged) : ctl_reg;
    ctl_next.start = startNext;
  end

  // Control and analog setup registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_reg  <= sadtc_ctl_t'(SADTC_CTL_RST);
      actl_reg <= SADTC_ACTL_RST;
    end else begin
      ctl_reg <= ctl_next;
      if (wrActl) begin
        actl_reg <= sadtcMerge(actl_reg, avsWriteData, avsByteEnable,
                               SADTC_ACTL_WMASK);
      end
    end
  end

  wire        loadDma  = convDone & ctl_reg.dmaEn;
  wire [31:0] fmtWord  = dmaWord32 ?
    {14'h0, convResult.valid, convResult.ov, 4'h0, convResult.result} :
    {20'h0, convResult.result};
  wire        dmaOvr   = loadDma & dmaReq_reg & ~dmaAck;

  // DMA word and request; a new load wins over the ack
  always_ff @(posedge clk) begin
    if (reset) begin
      word_reg   <= SADTC_WORD_RST;
      dmaReq_reg <= 1'h0;
    end else begin
      if (loadDma) begin
        word_reg <= fmtWord;
      end
      dmaReq_reg <= loadDma | (dmaReq_reg & ~dmaAck);
    end
  end

  // Sticky events; a set in the clearing cycle wins
  wire [2:0] events = {hwFire, dmaOvr, cycleDone};
  wire [2:0] irqGate = {2'h3, ctl_reg.irqEn};
  assign stat_next = (stat_reg & ~statClr) | events;

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_reg <= SADTC_IRQ_RST;
      mask_reg <= SADTC_IRQ_RST;
      irq_reg  <= 1'h0;
    end else begin
      stat_reg <= stat_next;
      if (wrMask) begin
        mask_reg <= maskMerged[2:0];
      end
      irq_reg <= |(stat_reg & mask_reg & irqGate);
    end
  end

  // Outputs straight from registers
  assign avsReadData    = rdata_reg;
  assign avsWaitRequest = wait_reg;
  assign convRun        = ctl_reg.start;
  assign adcEnable      = ctl_reg.adcEn;
  assign operating_mode_field         = ctl_reg.mode;
  assign refMicBias     = actl_reg[SADTC_VREF_BIT];
  assign singleEnded    = actl_reg[SADTC_SE_BIT];
  assign dmaReq         = dmaReq_reg;
  assign dmaData        = word_reg;
  assign irq            = irq_reg;

  // Assertion helpers
  wire rdWord = avsRead & accept & hitWord;
  wire wrVref = wrActl & avsByteEnable[2];
  wire [1:0] resFlags = {convResult.valid, convResult.ov};

  AST_MONITOR: assert property (@(posedge clk) disable iff (reset)
    rdWord & ~$past(loadDma) |-> avsReadData == {14'h0, monWord})
    else $error("monitor read mismatch");

  AST_WORD32: assert property (@(posedge clk) disable iff (reset)
    loadDma & dmaWord32 |=> dmaReq &&
      dmaData == {14'h0, $past(resFlags), 4'h0, $past(convResult.result)})
    else $error("32-bit DMA word lacks flags");

  AST_WORD16: assert property (@(posedge clk) disable iff (reset)
    loadDma & ~dmaWord32 |=> dmaData == {20'h0, $past(convResult.result)} && dmaReq)
    else $error("16-bit DMA word carries extra bits");

  AST_NOSIDE: assert property (@(posedge clk) disable iff (reset)
    rdWord & ~loadDma & ~dmaAck |=> $stable(dmaData) && $stable(dmaReq))
    else $error("monitor read disturbed DMA");

  AST_VREF: assert property (@(posedge clk) disable iff (reset)
    wrVref |=> refMicBias == $past(avsWriteData[SADTC_VREF_BIT]))
    else $error("reference select not written");

  AST_STOP: assert property (@(posedge clk) disable iff (reset)
    swStart & ~avsWriteData[11] & ~hwFire |=> ~convRun)
    else $error("software stop ignored");

  AST_AUTO: assert property (@(posedge clk) disable iff (reset)
    autoStop & ~swStart & ~hwFire |=>
      ~convRun ##1 (~convRun | $past(swStart) | $past(hwFire)))
    else $error("start bit not cleared at end of pass");

  AST_CONT: assert property (@(posedge clk) disable iff (reset)
    convRun & (operating_mode_field == SADTC_SCANC) & ~swStart |=> convRun)
    else $error("continuous scan stopped");

  AST_DMAREQ: assert property (@(posedge clk) disable iff (reset)
    convDone & ctl_reg.dmaEn |=> dmaReq)
    else $error("no DMA request after result load");

  AST_HWGATE: assert property (@(posedge clk) disable iff (reset)
    ~convRun & ~swStart & (~ctl_reg.hwEn | (operating_mode_field != SADTC_SCAN1)) |=> ~convRun)
    else $error("hardware start while gated");

  AST_TRIG: assert property (@(posedge clk) disable iff (reset)
    hwFire |=> convRun && stat_reg[SADTC_IRQ_TRIG])
    else $error("trigger event did not start");

  AST_IRQEN: assert property (@(posedge clk) disable iff (reset)
    ~ctl_reg.irqEn & (mask_reg[2:1] == 2'h0) |=> ~irq)
    else $error("conversion irq while disabled");

  AST_RSVD: assert property (@(posedge clk) disable iff (reset)
    avsRead & accept & hitCtl |-> avsReadData[31:12] == 20'h0 && ~avsReadData[10])
    else $error("reserved control bits read nonzero");

  AST_MONZERO: assert property (@(posedge clk) disable iff (reset)
    rdWord |-> avsReadData[31:18] == 14'h0)
    else $error("monitor upper bits nonzero");

  AST_MIC_BIAS_OUTPUT: assert property (@(posedge clk) disable iff (reset)
    wrVref & avsWriteData[SADTC_VREF_BIT] |=> refMicBias)
    else $error("mic bias reference not selected");

  AST_SWSTART: assert property (@(posedge clk) disable iff (reset)
    swStart & avsWriteData[11] |=> convRun)
    else $error("software start ignored");

  AST_SETSRC: assert property (@(posedge clk) disable iff (reset)
    $rose(convRun) |-> $past(swStart) || $past(hwFire))
    else $error("start bit set without a source");

  AST_HOLDREQ: assert property (@(posedge clk) disable iff (reset)
    dmaReq & ~dmaAck |=> dmaReq)
    else $error("DMA request dropped before ack");

  AST_MODEFLD: assert property (@(posedge clk) disable iff (reset)
    wrCtl & avsByteEnable[0] |=> operating_mode_field == $past(avsWriteData[3:2]))
    else $error("mode field not written");

  AST_IRQON: assert property (@(posedge clk) disable iff (reset)
    ctl_reg.irqEn & mask_reg[0] & stat_reg[0] |=> irq)
    else $error("enabled conversion irq missing");

endmodule

// file: bench/sadtc_partner.sv
/*
  Far side model: converter core and DMA controller, behavioural.
  Assumes the control block on the same clk with synchronous reset.
*/
module sadtc_partner
  import sadtc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Converter core
  input  wire logic          convRun,
  input  wire sadtc_mode_t   operating_mode_field,
  output logic               convDone,
  output sadtc_result_t      convResult,
  output logic               cycleDone,
  output sadtc_result_t      lastRes,
  // DMA controller
  input  wire logic          word32Sel,
  input  wire logic          dmaReq,
  input  wire logic [31:0]   dmaData,
  output logic               dmaWord32,
  output logic               dmaAck,
  output logic      [31:0]   ackWord
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0]  tick;
  logic        nConv;
  logic [3:0]  ackCnt;
  logic [11:0] seq;

  assign dmaWord32 = word32Sel;

  // One load per 16 cycles, two per scan pass; idle result lines toggle
  always_ff @(posedge clk) begin
    convDone <= 1'h0;
    cycleDone <= 1'h0;
    convResult <= ~convResult;
    if (reset) begin
      tick <= 4'h0;
      nConv <= 1'h0;
      seq <= 12'h5A3;
      convResult <= '0;
      lastRes <= '0;
    end else if (!convRun) begin
      tick <= 4'h0;
      nConv <= 1'h0;
    end else begin
      tick <= tick + 4'h1;
      cycleDone <= (tick == 4'h8) && (operating_mode_field == SADTC_SINGLE || !nConv);
      if (tick == 4'h7) begin
        convDone <= 1'h1;
        convResult <= {1'h1, 1'h0, seq};
        lastRes <= {1'h1, 1'h0, seq};
        seq <= seq + 12'h111;
        nConv <= (operating_mode_field == SADTC_SINGLE) ? 1'h0 : !nConv;
      end
    end
  end

  // DMA controller takes the word ten cycles after the request
  always_ff @(posedge clk) begin
    dmaAck <= 1'h0;
    if (reset) begin
      ackCnt <= 4'h0;
      ackWord <= 32'h0;
    end else if (!dmaReq || dmaAck) begin
      ackCnt <= 4'h0;
    end else if (ackCnt == 4'h9) begin
      dmaAck <= 1'h1;
      ackWord <= dmaData;
      ackCnt <= 4'h0;
    end else begin
      ackCnt <= ackCnt + 4'h1;
    end
  end
endmodule

// file: bench/sadtc_ctrl_tb_top.sv
/*
  Self-checking bench of the converter control block.
  Assumes the far side model and a 250 MHz clock.
*/
module sadtc_ctrl_tb_top
  import sadtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic          clk, reset, avsRead, avsWrite, avsWaitRequest, extStartPin, word32Sel;
  logic [6:0]    avsAddress;
  logic [31:0]   avsWriteData, avsReadData, dmaData, ackWord, expWord;
  logic          convDone, cycleDone, convRun, adcEnable, refMicBias, singleEnded;
  logic          dmaWord32, dmaAck, dmaReq, irq;
  sadtc_result_t convResult, lastRes;
  sadtc_mode_t   operating_mode_field;
  int            errCount, checks;
  wire logic [3:0] watch = {cycleDone, dmaAck, dmaReq, convRun};

  sadtc_ctrl uut (.clk(clk), .reset(reset), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsByteEnable(4'hF), .avsWriteData(avsWriteData),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .convDone(convDone),
    .convResult(convResult), .cycleDone(cycleDone), .convRun(convRun),
    .adcEnable(adcEnable), .operating_mode_field(operating_mode_field), .refMicBias(refMicBias),
    .singleEnded(singleEnded), .extStartPin(extStartPin), .dmaWord32(dmaWord32),
    .dmaAck(dmaAck), .dmaReq(dmaReq), .dmaData(dmaData), .irq(irq));

  sadtc_partner far (.clk(clk), .reset(reset), .convRun(convRun), .operating_mode_field(operating_mode_field),
    .convDone(convDone), .convResult(convResult), .cycleDone(cycleDone),
    .lastRes(lastRes), .word32Sel(word32Sel), .dmaReq(dmaReq), .dmaData(dmaData),
    .dmaWord32(dmaWord32), .dmaAck(dmaAck), .ackWord(ackWord));

  // Clock generator
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
      errCount++;
    end
  endtask

  // One bus cycle, held until waitrequest is sampled low
  task automatic busXfer(input logic w, input logic [6:0] a, input logic [31:0] d,
                         output logic [31:0] r);
    int n;
    n = 0;
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avsWaitRequest !== 1'h0 && n < 50);
    r = avsReadData;
    if (n >= 50) chk("bus wait", 32'h1, 32'h0);
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] r;
    busXfer(1'h1, a, d, r);
  endtask

  task automatic rdChk(input string nm, input logic [6:0] a, input logic [31:0] e);
    logic [31:0] r;
    busXfer(1'h0, a, 32'h0, r);
    chk(nm, r, e);
  endtask

  // Bounded wait for one watched bit
  task automatic waitBit(input int i, input logic v);
    int n;
    for (n = 0; n < 500 && watch[i] !== v; n++) @(posedge clk);
    chk("wait", {31'h0, watch[i]}, {31'h0, v});
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  // Low for 12 cycles, then a rising edge on the start pin
  task automatic pulsePin();
    extStartPin <= 1'h0;
    repeat (12) @(posedge clk);
    extStartPin <= 1'h1;
    repeat (20) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    complete_run();
  end

  // Test sequence
  initial begin
    {errCount, checks} = '0;
    {reset, avsRead, avsWrite, extStartPin, word32Sel} = 5'h10;
    avsAddress = 7'h0;
    avsWriteData = 32'h0;
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rdChk("monitor", SADTC_DMAWORD_OFS, SADTC_WORD_RST);
    rdChk("ctl", SADTC_CTL_OFS, SADTC_CTL_RST);
    rdChk("unmapped", 7'h40, 32'h0);
    wr(SADTC_CTL_OFS, 32'hFFFF_F400);
    rdChk("ctl rsvd", SADTC_CTL_OFS, 32'h0);
    wr(SADTC_ACTL_OFS, 32'hFFFF_FFFF);
    rdChk("actl", SADTC_ACTL_OFS, 32'h0004_0001);
    chk("refMicBias", {31'h0, refMicBias}, 32'h1);
    chk("singleEnded", {31'h0, singleEnded}, 32'h1);
    wr(SADTC_ACTL_OFS, 32'h0000_0001);
    chk("refMicBias", {31'h0, refMicBias}, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(SADTC_CTL_OFS, {28'h0, m[1:0], 2'h0});
      chk("operating_mode_field", {30'h0, operating_mode_field}, m);
      chk("adcEnable", {31'h0, adcEnable}, 32'h0);
    end
    $display("test registers done");
    // Single mode, 32-bit DMA words; interrupt enable kept off
    word32Sel <= 1'h1;
    wr(SADTC_CTL_OFS, 32'h0000_0A01);
    waitBit(1, 1'h1);
    expWord = {14'h0, lastRes.valid, lastRes.ov, 4'h0, lastRes.result};
    rdChk("monitor", SADTC_DMAWORD_OFS, {14'h0, expWord[17:0]});
    rdChk("monitor again", SADTC_DMAWORD_OFS, {14'h0, expWord[17:0]});
    chk("dmaReq held", {31'h0, dmaReq}, 32'h1);
    waitBit(2, 1'h1);
    chk("word32", ackWord, expWord);
    waitBit(0, 1'h0);
    rdChk("start cleared", SADTC_CTL_OFS, 32'h0000_0201);
    chk("adcEnable", {31'h0, adcEnable}, 32'h1);
    $display("test dma32 done");
    // Single-cycle scan, 16-bit DMA words
    word32Sel <= 1'h0;
    wr(SADTC_CTL_OFS, 32'h0000_0A09);
    repeat (2) begin
      waitBit(2, 1'h1);
      chk("word16", ackWord, {20'h0, lastRes.result});
      @(posedge clk);
    end
    waitBit(0, 1'h0);
    rdChk("scan cleared", SADTC_CTL_OFS, 32'h0000_0209);
    // Continuous scan runs until stopped
    wr(SADTC_CTL_OFS, 32'h0000_080D);
    repeat (3) begin
      waitBit(3, 1'h1);
      @(posedge clk);
    end
    chk("still running", {31'h0, convRun}, 32'h1);
    wr(SADTC_CTL_OFS, 32'h0000_000D);
    chk("stopped", {31'h0, convRun}, 32'h0);
    $display("test modes done");
    // Start pin trigger
    wr(SADTC_CTL_OFS, 32'h0000_01C1);
    pulsePin();
    chk("pin single mode", {31'h0, convRun}, 32'h0);
    wr(SADTC_CTL_OFS, 32'h0000_00C9);
    pulsePin();
    chk("pin disabled", {31'h0, convRun}, 32'h0);
    wr(SADTC_CTL_OFS, 32'h0000_01C9);
    extStartPin <= 1'h0;
    repeat (12) @(posedge clk);
    extStartPin <= 1'h1;
    waitBit(0, 1'h1);
    waitBit(0, 1'h0);
    rdChk("pin pass", SADTC_CTL_OFS, 32'h0000_01C9);
    // Falling edge, reserved source, then low and high level conditions
    wr(SADTC_CTL_OFS, 32'h0000_0189);
    extStartPin <= 1'h0;
    waitBit(0, 1'h1);
    waitBit(0, 1'h0);
    wr(SADTC_CTL_OFS, 32'h0000_0119);
    repeat (12) @(posedge clk);
    chk("reserved source", {31'h0, convRun}, 32'h0);
    wr(SADTC_CTL_OFS, 32'h0000_0109);
    waitBit(0, 1'h1);
    extStartPin <= 1'h1;
    waitBit(0, 1'h0);
    rdChk("low level pass", SADTC_CTL_OFS, 32'h0000_0109);
    wr(SADTC_CTL_OFS, 32'h0000_0149);
    waitBit(0, 1'h1);
    extStartPin <= 1'h0;
    waitBit(0, 1'h0);
    rdChk("high level pass", SADTC_CTL_OFS, 32'h0000_0149);
    $display("test trigger done");
    // Interrupt status, mask and enable
    wr(SADTC_STAT_OFS, 32'h0000_0007);
    wr(SADTC_MASK_OFS, 32'h0000_0001);
    wr(SADTC_CTL_OFS, 32'h0000_0801);
    waitBit(0, 1'h0);
    settle();
    chk("irq disabled", {31'h0, irq}, 32'h0);
    rdChk("status", SADTC_STAT_OFS, 32'h0000_0001);
    wr(SADTC_CTL_OFS, 32'h0000_0003);
    settle();
    chk("irq enabled", {31'h0, irq}, 32'h1);
    wr(SADTC_STAT_OFS, 32'h0000_0001);
    settle();
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(SADTC_MASK_OFS, 32'h0000_0000);
    wr(SADTC_CTL_OFS, 32'h0000_0803);
    waitBit(0, 1'h0);
    settle();
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdChk("status again", SADTC_STAT_OFS, 32'h0000_0001);
    $display("test interrupt done");
    complete_run();
  end
endmodule
